/* File: include/lpm_pkg.sv */
// Purpose: shared types and constants for the low power mode controller
// Assumes: one clock, no software-reachable registers; mode select is a plain input
// Notes: gate outputs are run enables, high means the unit keeps running
// Functional notes
// - mode select is latched first; only the standby instruction enters a low power mode
// - reset returns the device straight to run; any enabled interrupt wakes it into interrupt processing
// - independent watchdog and its oscillator keep running in sleep and standby
// - voltage detector and power-on reset circuit keep running in both modes
// - port output disable runs in sleep, halts with state kept in standby
// - both eight-bit timer units count in sleep, halt with counts kept in standby
package lpm_pkg;

  typedef enum logic [1:0] {
    LPM_RUN     = 2'b00,
    LPM_SLEEP   = 2'b01,
    LPM_STANDBY = 2'b10,
    LPM_WAKE    = 2'b11
  } lpm_state_t;

  // run enables toward clock sources and clock gates
  typedef struct packed {
    logic cpu;
    logic watchdog;
    logic main_osc;
    logic hs_osc;
    logic ls_osc;
    logic pll;
    logic independent_watchdog_osc;
    logic independent_watchdog;
    logic voltage_detector;
    logic por;
    logic ram;
    logic flash;
    logic data_transfer_unit;
    logic port_output_disable;
    logic [1:0] eight_bit_timer;
    logic peripherals;
  } lpm_run_t;

  localparam logic MODE_SLEEP = 1'b0;
  localparam logic MODE_STANDBY = 1'b1;
  localparam logic MODE_RESET = MODE_SLEEP;

endpackage

/* File: rtl/lpm_ctrl.sv */
// Purpose: low power mode controller, sequences sleep and software standby
// Assumes: cpu and interrupt inputs are synchronous to sys_clk
// Notes: wake_ack pulses one cycle when the cpu must take the waking interrupt
`timescale 1ns/1ps
module lpm_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // cpu side
  input wire logic mode_wr,
  input wire logic mode_sel,
  input wire logic standby_instr,
  input wire logic irq_pending,
  // status
  output logic mode_q,
  output logic in_low_power,
  output logic wake_ack,
  output lpm_pkg::lpm_state_t state,
  // run enables
  output lpm_pkg::lpm_run_t run_en
);

  lpm_pkg::lpm_state_t state_q;
  lpm_pkg::lpm_state_t state_d;
  // run enables, one register per concern, all loaded from the next state
  logic core_run_q;
  logic watchdog_run_q;
  logic main_osc_run_q;
  logic onchip_osc_run_q;
  logic pll_run_q;
  logic ram_run_q;
  logic flash_run_q;
  logic transfer_run_q;
  logic port_disable_run_q;
  logic [1:0] timer_run_q;
  logic peripherals_run_q;
  logic low_power_q;
  logic halt_next;
  logic standby_next;

  // the cpu is halted in sleep and in standby
  function automatic logic is_low_power(input lpm_pkg::lpm_state_t s);
    return (s == lpm_pkg::LPM_SLEEP) || (s == lpm_pkg::LPM_STANDBY);
  endfunction

  // state entered by the standby instruction for a latched mode
  function automatic lpm_pkg::lpm_state_t entry_target(input logic mode);
    return (mode == lpm_pkg::MODE_STANDBY) ? lpm_pkg::LPM_STANDBY : lpm_pkg::LPM_SLEEP;
  endfunction

  // mode select latch, written before the instruction
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= lpm_pkg::MODE_RESET;
    end else if (mode_wr) begin
      mode_q <= mode_sel;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      lpm_pkg::LPM_RUN: begin
        if (standby_instr) begin
          state_d = entry_target(mode_q);
        end
      end
      lpm_pkg::LPM_SLEEP, lpm_pkg::LPM_STANDBY: begin
        if (irq_pending) begin
          state_d = lpm_pkg::LPM_WAKE;
        end
      end
      lpm_pkg::LPM_WAKE: state_d = lpm_pkg::LPM_RUN;
      default: state_d = lpm_pkg::LPM_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= lpm_pkg::LPM_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // next-state decodes, registered below so every gate switches with the state
  assign halt_next = is_low_power(state_d);
  assign standby_next = (state_d == lpm_pkg::LPM_STANDBY);

  // cpu stops in both low power modes and comes back through the wake state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_run_q <= 1'b1;
    end else begin
      core_run_q <= !halt_next;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_run_q <= 1'b1;
    end else begin
      watchdog_run_q <= !halt_next;
    end
  end

  // oscillators and pll stop only in standby
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_osc_run_q <= 1'b1;
    end else begin
      main_osc_run_q <= !standby_next;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      onchip_osc_run_q <= 1'b1;
    end else begin
      onchip_osc_run_q <= !standby_next;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pll_run_q <= 1'b1;
    end else begin
      pll_run_q <= !standby_next;
    end
  end

  // memories keep their contents while halted
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_run_q <= 1'b1;
    end else begin
      ram_run_q <= !standby_next;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_run_q <= 1'b1;
    end else begin
      flash_run_q <= !standby_next;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      transfer_run_q <= 1'b1;
    end else begin
      transfer_run_q <= !standby_next;
    end
  end

  // output disable logic and timers keep their state, only their clock stops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_disable_run_q <= 1'b1;
    end else begin
      port_disable_run_q <= !standby_next;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_run_q <= 2'b11;
    end else begin
      timer_run_q <= {2{!standby_next}};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      peripherals_run_q <= 1'b1;
    end else begin
      peripherals_run_q <= !standby_next;
    end
  end

  // status flag loaded alongside the state register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_power_q <= 1'b0;
    end else begin
      low_power_q <= halt_next;
    end
  end

  // run enables toward clock sources and gates; supervisors never stop
  always_comb begin
    run_en.cpu = core_run_q;
    run_en.watchdog = watchdog_run_q;
    run_en.main_osc = main_osc_run_q;
    run_en.hs_osc = onchip_osc_run_q;
    run_en.ls_osc = onchip_osc_run_q;
    run_en.pll = pll_run_q;
    run_en.independent_watchdog_osc = 1'b1;
    run_en.independent_watchdog = 1'b1;
    run_en.voltage_detector = 1'b1;
    run_en.por = 1'b1;
    run_en.ram = ram_run_q;
    run_en.flash = flash_run_q;
    run_en.data_transfer_unit = transfer_run_q;
    run_en.port_output_disable = port_disable_run_q;
    run_en.eight_bit_timer = timer_run_q;
    run_en.peripherals = peripherals_run_q;
  end

  assign state = state_q;
  assign in_low_power = low_power_q;
  assign wake_ack = (state_q == lpm_pkg::LPM_WAKE);

endmodule // lpm_ctrl

/* File: testbench/low_power_mode_control_bench.sv */
// Purpose: bench for lpm_ctrl
// Assumes: model drives requests
// Notes: one cycle steps per hand-over
`timescale 1ns/1ps
module low_power_mode_control_bench;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic mode_wr, mode_sel, standby_instr, irq_pending, mode_q, in_low_power, wake_ack;
  lpm_pkg::lpm_state_t state;
  lpm_pkg::lpm_run_t run_en;
  int mismatches = 0;
  int checked = 0;
  always #5 sys_clk = ~sys_clk;
  lpm_cpu_model u_lpm_cpu_model (.sys_clk, .mode_wr, .mode_sel, .standby_instr, .irq_pending);
  lpm_ctrl u_lpm_ctrl (.sys_clk, .reset_n, .mode_wr, .mode_sel, .standby_instr, .irq_pending,
    .mode_q, .in_low_power, .wake_ack, .state, .run_en);
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t_mode(input logic m, input logic [16:0] r);
    u_lpm_cpu_model.enter(m);
    #1 check({15'h0, state}, {15'h0, m, !m});
    check({16'h0, in_low_power}, 17'h1);
    check({16'h0, mode_q}, {16'h0, m});
    check(run_en, r);
    u_lpm_cpu_model.irq(1'b1);
    @(posedge sys_clk) #1 check({16'h0, wake_ack}, 17'h1);
    check(run_en, 17'h1ffff);
    u_lpm_cpu_model.irq(1'b0);
    #1 check({15'h0, state}, 17'h0);
    check({15'h0, wake_ack, in_low_power}, 17'h0);
    $display("mode %0d done", m);
  endtask
  task automatic t_ignored;
    u_lpm_cpu_model.irq(1'b1);
    @(posedge sys_clk) #1 check({16'h0, wake_ack}, 17'h0);
    check({15'h0, state}, 17'h0);
    u_lpm_cpu_model.irq(1'b0);
    u_lpm_cpu_model.enter(1'b0);
    u_lpm_cpu_model.enter(1'b1);
    #1 check({15'h0, state}, 17'h1);
    check({16'h0, mode_q}, 17'h1);
    u_lpm_cpu_model.irq(1'b1);
    @(posedge sys_clk) #1 check({16'h0, wake_ack}, 17'h1);
    u_lpm_cpu_model.irq(1'b0);
    $display("ignored requests done");
  endtask
  task automatic t_reset;
    u_lpm_cpu_model.enter(1'b1);
    #1 check({15'h0, state}, 17'h2);
    @(posedge sys_clk) reset_n <= 1'b0;
    #1 check({15'h0, state}, 17'h0);
    check(run_en, 17'h1ffff);
    check({14'h0, mode_q, in_low_power, wake_ack}, 17'h0);
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk) #1 check({15'h0, state}, 17'h0);
    check(run_en, 17'h1ffff);
    $display("mid-run reset done");
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_mode(1'b0, 17'h07fff);
    t_mode(1'b1, 17'h00780);
    t_mode(1'b0, 17'h07fff);
    t_ignored;
    t_reset;
    print_verdict;
  end
endmodule // low_power_mode_control_bench

/* File: testbench/lpm_cpu_model.sv */
// Purpose: cpu and interrupt source
// Assumes: tasks called by the bench
// Notes: mode_sel flips once unqualified
`timescale 1ns/1ps
module lpm_cpu_model (
  // clock
  input wire logic sys_clk,
  // requests
  output logic mode_wr = 1'b0,
  output logic mode_sel = 1'b0,
  output logic standby_instr = 1'b0,
  output logic irq_pending = 1'b0
);
  task automatic enter(input logic m);
    @(posedge sys_clk);
    {mode_wr, mode_sel} <= {1'b1, m};
    @(posedge sys_clk);
    {mode_wr, mode_sel, standby_instr} <= {1'b0, !m, 1'b1};
    @(posedge sys_clk);
    standby_instr <= 1'b0;
  endtask
  task automatic irq(input logic v);
    @(posedge sys_clk);
    irq_pending <= v;
  endtask
endmodule // lpm_cpu_model

/* File: testbench/lpm_ctrl_properties.sv */
// Purpose: port checks for lpm_ctrl
// Assumes: one clock
// Notes: bound below
`timescale 1ns/1ps
module lpm_ctrl_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // cpu side
  input wire logic standby_instr,
  input wire logic irq_pending,
  // status and run enables
  input wire logic mode_q,
  input wire logic in_low_power,
  input wire logic wake_ack,
  input wire lpm_pkg::lpm_state_t state,
  input wire lpm_pkg::lpm_run_t run_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_wake;
    wake_ack && &run_en ##1 state == lpm_pkg::LPM_RUN;
  endsequence
  chk_mode_entry: assert property (state == lpm_pkg::LPM_RUN && standby_instr
    |=> in_low_power && state[1] == $past(mode_q)) else $error("bad entry");
  chk_instr_ignored: assert property (in_low_power && !irq_pending |=> $stable(state))
    else $error("left low power without interrupt");
  chk_wake_path: assert property (in_low_power && irq_pending |=> s_wake) else $error("wake");
  chk_watchdog_alive: assert property (in_low_power |-> run_en[10:9] == 2'h3)
    else $error("independent watchdog stopped");
  chk_supply_watch: assert property (in_low_power |-> run_en[8:7] == 2'h3)
    else $error("supervisor stopped");
  chk_pod_mode: assert property (in_low_power |-> run_en[3] == state[0]) else $error("pod");
  chk_timer_mode: assert property (in_low_power |-> run_en[2:1] == {2{state[0]}})
    else $error("timer");
  chk_halt_map: assert property (in_low_power |-> run_en == (state[0] ? 17'h07fff : 17'h00780))
    else $error("map");
endmodule // lpm_ctrl_properties
bind lpm_ctrl lpm_ctrl_properties u_lpm_ctrl_properties (.sys_clk, .reset_n, .standby_instr,
  .irq_pending, .mode_q, .in_low_power, .wake_ack, .state, .run_en);
